/* File: design/p1pb_pkg.sv */
// Register map, field positions and reset values for the port 1 PHY control bank
package p1pb_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address = 4 * index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_RATE_HIGH  = 10'h07a;
   localparam logic [9:0] IDX_CABLE_SPEC = 10'h07c;
   localparam logic [9:0] IDX_MODE_CTRL  = 10'h07e;
   localparam logic [9:0] IDX_BASIC_CTRL = 10'h0e0;
   localparam logic [9:0] IDX_SPEC_CTRL  = 10'h0e2;
   localparam logic [9:0] IDX_AN_ADVERT  = 10'h0e4;
   localparam logic [9:0] IDX_RATE_CTRL  = 10'h0f0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_RATE_HIGH = 16'h0000;
   localparam logic [15:0] RST_MODE_CTRL = 16'h00ff;
   localparam logic        RST_CABLE_B10 = 1'b1;
   localparam logic        RST_RATE_EN   = 1'b0;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int RATE_P3_LSB  = 8;
   localparam int RATE_P2_LSB  = 0;
   localparam int RATE_W       = 7;
   localparam int CBL_SHORT    = 15;
   localparam int CBL_RES_LSB  = 13;
   localparam int CBL_START    = 12;
   localparam int CBL_FLINK    = 11;
   localparam int CBL_RSVD10   = 10;
   localparam int CBL_RLOOP    = 9;
   localparam int CBL_CNT_W    = 9;
   localparam int MC_TXDIS     = 14;
   localparam int MC_RESTART   = 13;
   localparam int MC_PDOWN     = 11;
   localparam int MC_NOMDIX    = 10;
   localparam int MC_FMDIX     = 9;
   localparam int MC_FELOOP    = 8;
   localparam int MC_ANEN      = 7;
   localparam int MC_SPEED     = 6;
   localparam int MC_DUPLEX    = 5;
   localparam int MC_ADV_PAUSE = 4;

   // ------------------------------------------------------------
   // Rate code decoding
   // ------------------------------------------------------------
   localparam logic [6:0]  RATE_MBPS_MAX   = 7'h64;
   localparam logic [6:0]  RATE_10BT_MAX   = 7'h0a;
   localparam logic [16:0] KBPS_PER_MBPS   = 17'h0_03e8;
   localparam logic [16:0] KBPS_PER_STEP   = 17'h0_0040;

   // ------------------------------------------------------------
   // Bus answers
   // ------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: design/p1pb_bank.sv */
// Port 1 PHY control and status register bank with AXI4-Lite slave
`timescale 1ns/10ps

module p1pb_bank #(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              cable_test_done,
   input  wire logic [1:0]        cable_test_result_in,
   input  wire logic              cable_short_in,
   input  wire logic [8:0]        cable_count_in,
   input  wire logic              an_failed,
   input  wire logic              an_full_duplex,
   input  wire logic              an_speed_100,
   output      logic              cable_test_go,
   output      logic              an_restart_go,
   output      logic              force_link,
   output      logic              remote_loopback,
   output      logic              far_end_loopback,
   output      logic              tx_disable,
   output      logic              power_down,
   output      logic              auto_mdix_off,
   output      logic              force_mdix,
   output      logic              an_enable,
   output      logic              link_speed_100,
   output      logic              link_full_duplex,
   output      logic [4:0]        advertise,
   output      logic              prio3_unlimited,
   output      logic [16:0]       prio3_limit_kbps,
   output      logic              prio2_unlimited,
   output      logic [16:0]       prio2_limit_kbps
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [15:0] rate_high_q;
   logic        rate_en_q;
   logic [15:0] mode_q;
   logic        start_q;
   logic        flink_q;
   logic        rsvd10_q;
   logic        rloop_q;
   logic        short_q;
   logic [1:0]  result_q;
   logic [8:0]  count_q;
   logic        go_q;
   logic        restart_go_q;

   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   logic              aw_held_q;
   logic              w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              wr_fire;
   logic [9:0]        wr_idx;
   logic [15:0]       wmask;
   logic [15:0]       wval;
   logic              wr_hit;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_idx  = awaddr_q[11:2];
   assign wmask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wval    = wdata_q[15:0];

   always_comb begin
      case (wr_idx)
         p1pb_pkg::IDX_RATE_HIGH,
         p1pb_pkg::IDX_CABLE_SPEC,
         p1pb_pkg::IDX_MODE_CTRL,
         p1pb_pkg::IDX_BASIC_CTRL,
         p1pb_pkg::IDX_SPEC_CTRL,
         p1pb_pkg::IDX_AN_ADVERT,
         p1pb_pkg::IDX_RATE_CTRL: wr_hit = 1'b1;
         default:                 wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= p1pb_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? p1pb_pkg::RESP_OKAY : p1pb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Rate limit registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_high_q <= p1pb_pkg::RST_RATE_HIGH;
      end else if (wr_fire && wr_idx == p1pb_pkg::IDX_RATE_HIGH) begin
         rate_high_q <= (rate_high_q & ~wmask) | (wval & wmask);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_en_q <= p1pb_pkg::RST_RATE_EN;
      end else if (wr_fire && wr_idx == p1pb_pkg::IDX_RATE_CTRL && wstrb_q[0]) begin
         rate_en_q <= wval[0];
      end
   end

   // ------------------------------------------------------------
   // Mode control, shared with basic control and advertisement
   // ------------------------------------------------------------
   logic [15:0] mode_d;

   always_comb begin
      mode_d = mode_q;
      if (restart_go_q) begin
         mode_d[p1pb_pkg::MC_RESTART] = 1'b0;
      end
      if (wr_fire && wr_idx == p1pb_pkg::IDX_MODE_CTRL) begin
         mode_d = (mode_d & ~wmask) | (wval & wmask);
      end else if (wr_fire && wr_idx == p1pb_pkg::IDX_BASIC_CTRL) begin
         if (wstrb_q[1]) begin
            mode_d[p1pb_pkg::MC_FELOOP]  = wval[14];
            mode_d[p1pb_pkg::MC_SPEED]   = wval[13];
            mode_d[p1pb_pkg::MC_ANEN]    = wval[12];
            mode_d[p1pb_pkg::MC_PDOWN]   = wval[11];
            mode_d[p1pb_pkg::MC_RESTART] = wval[9];
            mode_d[p1pb_pkg::MC_DUPLEX]  = wval[8];
         end
         if (wstrb_q[0]) begin
            mode_d[p1pb_pkg::MC_FMDIX]  = wval[4];
            mode_d[p1pb_pkg::MC_NOMDIX] = wval[3];
            mode_d[12]                  = wval[2];
            mode_d[p1pb_pkg::MC_TXDIS]  = wval[1];
         end
      end else if (wr_fire && wr_idx == p1pb_pkg::IDX_AN_ADVERT) begin
         if (wstrb_q[1]) begin
            mode_d[p1pb_pkg::MC_ADV_PAUSE] = wval[10];
            mode_d[3]                      = wval[8];
         end
         if (wstrb_q[0]) begin
            mode_d[2:0] = wval[7:5];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= p1pb_pkg::RST_MODE_CTRL;
      end else begin
         mode_q <= mode_d;
      end
   end

   // Restart pulse, bit clears one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         restart_go_q <= 1'b0;
      end else begin
         restart_go_q <= mode_q[p1pb_pkg::MC_RESTART] && !restart_go_q;
      end
   end

   // ------------------------------------------------------------
   // Cable test and special control
   // ------------------------------------------------------------
   logic start_wr;

   assign start_wr = wr_fire && wr_idx == p1pb_pkg::IDX_CABLE_SPEC && wstrb_q[1]
                     && wval[p1pb_pkg::CBL_START];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_q <= 1'b0;
      end else if (start_wr) begin
         start_q <= 1'b1;
      end else if (cable_test_done) begin
         start_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         go_q <= 1'b0;
      end else begin
         go_q <= start_wr && !start_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         short_q  <= 1'b0;
         result_q <= 2'b00;
         count_q  <= 9'h000;
      end else if (cable_test_done && start_q) begin
         short_q  <= cable_short_in;
         result_q <= cable_test_result_in;
         count_q  <= cable_count_in;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flink_q  <= 1'b0;
         rsvd10_q <= p1pb_pkg::RST_CABLE_B10;
         rloop_q  <= 1'b0;
      end else if (wr_fire && wr_idx == p1pb_pkg::IDX_CABLE_SPEC && wstrb_q[1]) begin
         flink_q  <= wval[p1pb_pkg::CBL_FLINK];
         rsvd10_q <= wval[p1pb_pkg::CBL_RSVD10];
         rloop_q  <= wval[p1pb_pkg::CBL_RLOOP];
      end else if (wr_fire && wr_idx == p1pb_pkg::IDX_SPEC_CTRL && wstrb_q[0]) begin
         flink_q <= wval[3];
         rloop_q <= wval[1];
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic [15:0] rd_val;
   logic        rd_hit;
   logic [9:0]  rd_idx;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   assign rd_idx        = s_axi_araddr[11:2];
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_comb begin
      rd_val = 16'h0000;
      rd_hit = 1'b1;
      case (rd_idx)
         p1pb_pkg::IDX_RATE_HIGH:  rd_val = rate_high_q;
         p1pb_pkg::IDX_CABLE_SPEC: rd_val = {short_q, result_q, start_q, flink_q, rsvd10_q, rloop_q, count_q};
         p1pb_pkg::IDX_MODE_CTRL:  rd_val = mode_q;
         p1pb_pkg::IDX_BASIC_CTRL: rd_val = {1'b0, mode_q[8], mode_q[6], mode_q[7], mode_q[11], 1'b0,
                                             mode_q[13], mode_q[5], 3'b000, mode_q[9], mode_q[10],
                                             mode_q[12], mode_q[14], 1'b0};
         p1pb_pkg::IDX_SPEC_CTRL:  rd_val = {12'h000, flink_q, 1'b0, rloop_q, 1'b0};
         p1pb_pkg::IDX_AN_ADVERT:  rd_val = {5'h00, mode_q[4], 1'b0, mode_q[3:0], 5'h00};
         p1pb_pkg::IDX_RATE_CTRL:  rd_val = {15'h0000, rate_en_q};
         default:                  rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= p1pb_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {16'h0000, rd_val};
         rresp_q  <= rd_hit ? p1pb_pkg::RESP_OKAY : p1pb_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Rate code decode
   // ------------------------------------------------------------
   function automatic logic [16:0] rate_kbps(input logic [6:0] code, input logic fast);
      logic [16:0] r;
      r = 17'h0_0000;
      if (code <= p1pb_pkg::RATE_MBPS_MAX) begin
         if (fast || code <= p1pb_pkg::RATE_10BT_MAX) begin
            r = 17'({10'h000, code} * p1pb_pkg::KBPS_PER_MBPS);
         end else begin
            r = 17'({10'h000, p1pb_pkg::RATE_10BT_MAX} * p1pb_pkg::KBPS_PER_MBPS);
         end
      end else begin
         r = 17'({10'h000, 7'(code - p1pb_pkg::RATE_MBPS_MAX)} * p1pb_pkg::KBPS_PER_STEP);
      end
      return r;
   endfunction

   logic [6:0] code3;
   logic [6:0] code2;

   assign code3 = rate_high_q[p1pb_pkg::RATE_P3_LSB +: p1pb_pkg::RATE_W];
   assign code2 = rate_high_q[p1pb_pkg::RATE_P2_LSB +: p1pb_pkg::RATE_W];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio3_unlimited  <= 1'b1;
         prio3_limit_kbps <= 17'h0_0000;
         prio2_unlimited  <= 1'b1;
         prio2_limit_kbps <= 17'h0_0000;
      end else begin
         prio3_unlimited  <= !rate_en_q || code3 == 7'h00;
         prio3_limit_kbps <= rate_kbps(code3, link_speed_100);
         prio2_unlimited  <= !rate_en_q || code2 == 7'h00;
         prio2_limit_kbps <= rate_kbps(code2, link_speed_100);
      end
   end

   // ------------------------------------------------------------
   // PHY mode outputs
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         force_link       <= 1'b0;
         remote_loopback  <= 1'b0;
         far_end_loopback <= 1'b0;
         tx_disable       <= 1'b0;
         power_down       <= 1'b0;
         auto_mdix_off    <= 1'b0;
         force_mdix       <= 1'b0;
         an_enable        <= 1'b1;
         link_speed_100   <= 1'b1;
         link_full_duplex <= 1'b1;
         advertise        <= 5'h1f;
      end else begin
         force_link       <= flink_q;
         remote_loopback  <= rloop_q;
         far_end_loopback <= mode_q[p1pb_pkg::MC_FELOOP];
         tx_disable       <= mode_q[p1pb_pkg::MC_TXDIS];
         power_down       <= mode_q[p1pb_pkg::MC_PDOWN];
         auto_mdix_off    <= mode_q[p1pb_pkg::MC_NOMDIX];
         force_mdix       <= mode_q[p1pb_pkg::MC_NOMDIX] && mode_q[p1pb_pkg::MC_FMDIX];
         an_enable        <= mode_q[p1pb_pkg::MC_ANEN];
         link_speed_100   <= mode_q[p1pb_pkg::MC_ANEN] && !an_failed ? an_speed_100
                             : mode_q[p1pb_pkg::MC_SPEED];
         link_full_duplex <= mode_q[p1pb_pkg::MC_ANEN] && !an_failed ? an_full_duplex
                             : mode_q[p1pb_pkg::MC_DUPLEX];
         advertise        <= mode_q[4:0];
      end
   end

   assign cable_test_go = go_q;
   assign an_restart_go = restart_go_q;

endmodule

/* File: testbench/p1pb_phy_model.sv */
// Cable-side PHY model answering cable test starts
`timescale 1ns/10ps
module p1pb_phy_model (
   input  wire logic       aclk,
   input  wire logic       cable_test_go,
   input  wire logic [1:0] res,
   input  wire logic       short_flag,
   input  wire logic [8:0] cnt,
   input  wire logic [7:0] lat,
   output      logic       done,
   output      logic [1:0] res_o,
   output      logic       short_o,
   output      logic [8:0] cnt_o
);
   int wait_n = -1;
   initial begin
      done = 1'b0;
      {res_o, short_o, cnt_o} = 12'h5a5;
   end
   // ------------------------------------------------------------
   // Results only valid with done, scrambled otherwise
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      done <= 1'b0;
      {res_o, short_o, cnt_o} <= ~{res_o, short_o, cnt_o};
      if (cable_test_go) begin
         wait_n <= int'(lat);
      end else if (wait_n > 0) begin
         wait_n <= wait_n - 1;
      end else if (wait_n == 0) begin
         done <= 1'b1;
         {res_o, short_o, cnt_o} <= {res, short_flag, cnt};
         wait_n <= -1;
      end
   end
endmodule

/* File: testbench/p1pb_bank_chk.sv */
// Concurrent checks on the port 1 PHY control bank ports
`timescale 1ns/10ps
module p1pb_bank_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        an_failed,
   input wire logic        an_speed_100,
   input wire logic        cable_test_go,
   input wire logic        an_restart_go,
   input wire logic        auto_mdix_off,
   input wire logic        force_mdix,
   input wire logic        an_enable,
   input wire logic        link_speed_100,
   input wire logic        prio3_unlimited,
   input wire logic [16:0] prio3_limit_kbps,
   input wire logic        prio2_unlimited,
   input wire logic [16:0] prio2_limit_kbps
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_go_pulse;
      cable_test_go |=> !cable_test_go;
   endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("cable test start not a pulse");
   property p_restart_pulse;
      an_restart_go |=> !an_restart_go;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart not a pulse");
   property p_mdix_needs_off;
      force_mdix |-> auto_mdix_off;
   endproperty
   a_mdix_needs_off: assert property (p_mdix_needs_off) else $error("mdix forced while auto on");
   property p_p3_range;
      !prio3_unlimited |-> prio3_limit_kbps inside {[17'h0_0001:17'h1_86a0]};
   endproperty
   a_p3_range: assert property (p_p3_range) else $error("priority 3 limit out of range");
   property p_p2_range;
      !prio2_unlimited |-> prio2_limit_kbps inside {[17'h0_0001:17'h1_86a0]};
   endproperty
   a_p2_range: assert property (p_p2_range) else $error("priority 2 limit out of range");
   property p_speed_neg;
      $past(aresetn) && an_enable && !$past(an_failed) |-> link_speed_100 == $past(an_speed_100);
   endproperty
   a_speed_neg: assert property (p_speed_neg) else $error("negotiated speed not used");
   property p_ar_refuse;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_refuse: assert property (p_ar_refuse) else $error("read taken during answer");
   property p_r_drop;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_drop: assert property (p_r_drop) else $error("read answer not released");
endmodule
bind p1pb_bank p1pb_bank_chk p1pb_bank_chk_inst (.aclk, .aresetn, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .an_failed, .an_speed_100, .cable_test_go, .an_restart_go, .auto_mdix_off, .force_mdix,
   .an_enable, .link_speed_100, .prio3_unlimited, .prio3_limit_kbps, .prio2_unlimited, .prio2_limit_kbps);

/* File: testbench/p1pb_bank_test.sv */
// Self-checking bench for the port 1 PHY control bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module p1pb_bank_test;
   logic        aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        an_failed = 1'b0, an_full_duplex = 1'b1, an_speed_100 = 1'b1, p_short = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  p_res = '0;
   logic [8:0]  p_cnt = '0;
   logic [7:0]  lfsr_q = 8'h26;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cable_test_done;
   logic [1:0]  s_axi_bresp, s_axi_rresp, cable_test_result_in;
   logic [31:0] s_axi_rdata;
   logic        cable_short_in, cable_test_go, an_restart_go, force_link, remote_loopback, far_end_loopback;
   logic        tx_disable, power_down, auto_mdix_off, force_mdix, an_enable, link_speed_100, link_full_duplex;
   logic [8:0]  cable_count_in;
   logic [4:0]  advertise;
   logic        prio3_unlimited, prio2_unlimited;
   logic [16:0] prio3_limit_kbps, prio2_limit_kbps;
   int          n_errors = 0, check_count = 0, n_restart = 0;
   int          mr[int];
   p1pb_bank p1pb_bank_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cable_test_done,
      .cable_test_result_in, .cable_short_in, .cable_count_in, .an_failed, .an_full_duplex, .an_speed_100,
      .cable_test_go, .an_restart_go, .force_link, .remote_loopback, .far_end_loopback, .tx_disable, .power_down,
      .auto_mdix_off, .force_mdix, .an_enable, .link_speed_100, .link_full_duplex, .advertise, .prio3_unlimited,
      .prio3_limit_kbps, .prio2_unlimited, .prio2_limit_kbps);
   p1pb_phy_model p1pb_phy_model_inst (.aclk, .cable_test_go, .res(p_res), .short_flag(p_short), .cnt(p_cnt),
      .lat(8'h14), .done(cable_test_done), .res_o(cable_test_result_in), .short_o(cable_short_in),
      .cnt_o(cable_count_in));
   always #20 aclk = ~aclk;
   always @(posedge aclk) if (an_restart_go === 1'b1) n_restart++;
   // ------------------------------------------------------------
   // Bus tasks and model
   // ------------------------------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic int kbps(int c, bit s100);
      if (c > 100) return (c - 100) * 64;
      if (!s100 && c > 10) return 10000;
      return c * 1000;
   endfunction
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      `CHK("bresp", er, s_axi_bresp)
      repeat (2) @(posedge aclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [15:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata[15:0];
      `CHK("rresp", er, s_axi_rresp)
      `CHK("rdata_hi", 16'h0000, s_axi_rdata[31:16])
   endtask
   task automatic rdc(input logic [11:0] a);
      logic [15:0] v;
      rd(a, 2'b00, v);
      `CHK("reg", 16'(mr[a]), v)
   endtask
   task automatic chk_rate(int c3, int c2, bit s100);
      `CHK("p3_unlim", c3 == 0, prio3_unlimited)
      `CHK("p2_unlim", c2 == 0, prio2_unlimited)
      if (c3 != 0) `CHK("p3_kbps", 17'(kbps(c3, s100)), prio3_limit_kbps)
      if (c2 != 0) `CHK("p2_kbps", 17'(kbps(c2, s100)), prio2_limit_kbps)
   endtask
   task automatic results;
      $display("Errors %0d of %0d checks", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      results;
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      int c3, c2;
      logic [15:0] v;
      static logic [6:0] tbl [5] = '{7'h00, 7'h01, 7'h64, 7'h65, 7'h7f};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      mr[12'h1e8] = 16'h0000;
      mr[12'h1f0] = 16'h0400;
      mr[12'h1f8] = 16'h00ff;
      @(posedge aclk);
      foreach (mr[a]) rdc(12'(a));
      `CHK("advertise", 5'h1f, advertise)
      `CHK("an_enable", 1'b1, an_enable)
      rd(12'h004, 2'b10, v);
      `CHK("unmapped", 16'h0000, v)
      wr(12'h008, 16'hffff, 2'b10);
      wr(12'h3c0, 16'h0001, 2'b00);
      for (int i = 0; i < 9; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         c3 = (i < 5) ? int'(tbl[i]) : int'(lfsr_q[6:0]);
         lfsr_q = lfsr_next(lfsr_q);
         c2 = int'(lfsr_q[6:0]);
         mr[12'h1e8] = c3 * 256 + c2;
         wr(12'h1e8, 16'(mr[12'h1e8]), 2'b00);
         chk_rate(c3, c2, 1'b1);
         rdc(12'h1e8);
      end
      wr(12'h3c0, 16'h0000, 2'b00);
      mr[12'h1e8] = 16'h7f7f;
      wr(12'h1e8, 16'h7f7f, 2'b00);
      `CHK("p3_off", 1'b1, prio3_unlimited)
      `CHK("p2_off", 1'b1, prio2_unlimited)
      for (int r = 0; r < 4; r++) begin
         lfsr_q = lfsr_next(lfsr_q);
         p_res <= 2'(r);
         p_short <= r[0];
         p_cnt <= {1'b1, lfsr_q};
         mr[12'h1f0] = mr[12'h1f0] | 16'h1000;
         wr(12'h1f0, 16'(mr[12'h1f0]), 2'b00);
         rdc(12'h1f0);
         while (cable_test_done !== 1'b1) begin
            @(posedge aclk);
         end
         repeat (2) @(posedge aclk);
         mr[12'h1f0] = (mr[12'h1f0] & 16'h0e00) + r[0] * 32768 + r * 8192 + 256 + int'(lfsr_q);
         rdc(12'h1f0);
      end
      wr(12'h388, 16'h000a, 2'b00);
      mr[12'h1f0] = mr[12'h1f0] | 16'h0a00;
      rdc(12'h1f0);
      `CHK("force_link", 1'b1, force_link)
      `CHK("rloop", 1'b1, remote_loopback)
      mr[12'h1f8] = 16'h4f00;
      wr(12'h1f8, 16'h4f00, 2'b00);
      `CHK("tx_dis", 1'b1, tx_disable)
      `CHK("pdown", 1'b1, power_down)
      `CHK("mdix_off", 1'b1, auto_mdix_off)
      `CHK("fmdix", 1'b1, force_mdix)
      `CHK("feloop", 1'b1, far_end_loopback)
      `CHK("an_off", 1'b0, an_enable)
      `CHK("speed", 1'b0, link_speed_100)
      `CHK("duplex", 1'b0, link_full_duplex)
      `CHK("adv_off", 5'h00, advertise)
      rd(12'h380, 2'b00, v);
      `CHK("basic", 16'h481a, v)
      rdc(12'h1e8);
      wr(12'h3c0, 16'h0001, 2'b00);
      mr[12'h1e8] = 16'h3232;
      wr(12'h1e8, 16'h3232, 2'b00);
      chk_rate(50, 50, 1'b0);
      mr[12'h1f8] = 16'h0200;
      wr(12'h1f8, 16'h0200, 2'b00);
      `CHK("fmdix_auto", 1'b0, force_mdix)
      an_failed <= 1'b1;
      an_speed_100 <= 1'b0;
      mr[12'h1f8] = 16'h00c0;
      wr(12'h380, 16'h3000, 2'b00);
      `CHK("speed_fail", 1'b1, link_speed_100)
      `CHK("duplex_fail", 1'b0, link_full_duplex)
      rdc(12'h1f8);
      an_failed <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("speed_an", 1'b0, link_speed_100)
      `CHK("duplex_an", 1'b1, link_full_duplex)
      wr(12'h1f8, 16'h20c0, 2'b00);
      `CHK("restart", 1, n_restart)
      rdc(12'h1f8);
      mr[12'h1f8] = 16'h0095;
      wr(12'h1f8, 16'h0095, 2'b00);
      `CHK("advertise", 5'h15, advertise)
      rd(12'h390, 2'b00, v);
      `CHK("an_adv", 16'h04a0, v)
      results;
   end
endmodule
